/* File: rtl/stm_pkg.sv */
// constants for the standard timer module
`default_nettype none
package stm_pkg;
  // ----------------------------------------------------------------
  // register indices
  // ----------------------------------------------------------------
  localparam logic [2:0] ADDR_CTRL0 = 3'h0;
  localparam logic [2:0] ADDR_CTRL1 = 3'h1;
  localparam logic [2:0] ADDR_CNT_LO = 3'h2;
  localparam logic [2:0] ADDR_CNT_HI = 3'h3;
  localparam logic [2:0] ADDR_CMPA_LO = 3'h4;
  localparam logic [2:0] ADDR_CMPA_HI = 3'h5;
  localparam logic [2:0] ADDR_CMPP = 3'h6;
  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int PAUSE_BIT = 7;
  localparam int CKSEL_HI = 6;
  localparam int CKSEL_LO = 4;
  localparam int ON_BIT = 3;
  localparam int MODE_HI = 7;
  localparam int MODE_LO = 6;
  localparam int PINF_HI = 5;
  localparam int PINF_LO = 4;
  localparam int OC_BIT = 3;
  localparam int POL_BIT = 2;
  localparam int DPX_BIT = 1;
  localparam int CCLR_BIT = 0;
  localparam logic [7:0] CTRL0_RD_MASK = 8'hf8;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  // ----------------------------------------------------------------
  // modes, pin functions, clock selects
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_CMP = 2'h0;
  localparam logic [1:0] MODE_PWM = 2'h2;
  localparam logic [1:0] MODE_TC = 2'h3;
  localparam logic [1:0] PINF_00 = 2'h0;
  localparam logic [1:0] PINF_01 = 2'h1;
  localparam logic [1:0] PINF_10 = 2'h2;
  localparam logic [1:0] PINF_11 = 2'h3;
  localparam logic [2:0] CK_SYS4 = 3'h0;
  localparam logic [2:0] CK_SYS = 3'h1;
  localparam logic [2:0] CK_H16 = 3'h2;
  localparam logic [2:0] CK_H64 = 3'h3;
  localparam logic [2:0] CK_SUB0 = 3'h4;
  localparam logic [2:0] CK_SUB1 = 3'h5;
  localparam logic [2:0] CK_EXTR = 3'h6;
  localparam logic [2:0] CK_EXTF = 3'h7;
  // ----------------------------------------------------------------
  // prescaler: high clock is taken as the system clock
  // ----------------------------------------------------------------
  localparam logic [5:0] DIV4_MASK = 6'h03;
  localparam logic [5:0] DIV16_MASK = 6'h0f;
  localparam logic [5:0] DIV64_MASK = 6'h3f;
  localparam int SYS_HZ = 40_000_000;
  localparam int SUB_HZ = 32_768;
  localparam int SUB_DIV = SYS_HZ / SUB_HZ;
  localparam logic [10:0] SUB_LAST = 11'(SUB_DIV - 1);
  localparam logic [10:0] SUB_ZERO = 11'h000;
endpackage : stm_pkg
`default_nettype wire

/* File: rtl/standard_timer_module.sv */
// 16-bit standard timer with two comparators, pwm and compare output
//
// Decided for this implementation: the register addresses and the address-and-strobe port.
`default_nettype none
module standard_timer_module (
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       external_clock_pin,
  output logic            timer_output_pin,
  output logic            timer_output_pin_oe,
  output logic            compare_a_flag,
  output logic            compare_p_flag
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0]  ctrl0_r;
  logic [7:0]  ctrl1_r;
  logic [15:0] cmpa_r;
  logic [7:0]  cmpp_r;
  logic [15:0] cnt_r;
  logic        on_d_r;
  logic        pin_r;

  logic       pause_bit;
  logic [2:0] clock_select_field;
  logic       on_off_bit;
  logic [1:0] mode_select_field;
  logic [1:0] pin_function_field;
  logic       output_control_bit;
  logic       polarity_bit;
  logic       duty_period_select;
  logic       counter_clear_select;

  assign pause_bit            = ctrl0_r[stm_pkg::PAUSE_BIT];
  assign clock_select_field   = ctrl0_r[stm_pkg::CKSEL_HI:stm_pkg::CKSEL_LO];
  assign on_off_bit           = ctrl0_r[stm_pkg::ON_BIT];
  assign mode_select_field    = ctrl1_r[stm_pkg::MODE_HI:stm_pkg::MODE_LO];
  assign pin_function_field   = ctrl1_r[stm_pkg::PINF_HI:stm_pkg::PINF_LO];
  assign output_control_bit   = ctrl1_r[stm_pkg::OC_BIT];
  assign polarity_bit         = ctrl1_r[stm_pkg::POL_BIT];
  assign duty_period_select   = ctrl1_r[stm_pkg::DPX_BIT];
  assign counter_clear_select = ctrl1_r[stm_pkg::CCLR_BIT];

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl0_r <= stm_pkg::BYTE_RESET;
      ctrl1_r <= stm_pkg::BYTE_RESET;
      cmpa_r  <= stm_pkg::CNT_RESET;
      cmpp_r  <= stm_pkg::BYTE_RESET;
    end else if (reg_wr) begin
      case (reg_addr)
        stm_pkg::ADDR_CTRL0:   ctrl0_r <= reg_wdata & stm_pkg::CTRL0_RD_MASK;
        stm_pkg::ADDR_CTRL1:   ctrl1_r <= reg_wdata;
        stm_pkg::ADDR_CMPA_LO: cmpa_r[7:0] <= reg_wdata;
        stm_pkg::ADDR_CMPA_HI: cmpa_r[15:8] <= reg_wdata;
        stm_pkg::ADDR_CMPP:    cmpp_r <= reg_wdata;
        default: ;
      endcase
    end
  end

  // counter bytes are read only; writes there are dropped
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= stm_pkg::BYTE_RESET;
    end else if (reg_rd) begin
      case (reg_addr)
        stm_pkg::ADDR_CTRL0:   reg_rdata <= ctrl0_r;
        stm_pkg::ADDR_CTRL1:   reg_rdata <= ctrl1_r;
        stm_pkg::ADDR_CNT_LO:  reg_rdata <= cnt_r[7:0];
        stm_pkg::ADDR_CNT_HI:  reg_rdata <= cnt_r[15:8];
        stm_pkg::ADDR_CMPA_LO: reg_rdata <= cmpa_r[7:0];
        stm_pkg::ADDR_CMPA_HI: reg_rdata <= cmpa_r[15:8];
        stm_pkg::ADDR_CMPP:    reg_rdata <= cmpp_r;
        default:               reg_rdata <= stm_pkg::BYTE_ZERO;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // clock enables
  // ----------------------------------------------------------------
  logic [5:0]  pre_r;
  logic [10:0] sub_r;
  logic        ext_q1_r;
  logic        ext_q2_r;
  logic        ext_q3_r;
  logic        ext_lvl_r;
  logic        ext_rise;
  logic        ext_fall;
  logic        clk_en;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pre_r <= '0;
    end else begin
      pre_r <= pre_r + 6'h01;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sub_r <= stm_pkg::SUB_ZERO;
    end else if (sub_r == stm_pkg::SUB_LAST) begin
      sub_r <= stm_pkg::SUB_ZERO;
    end else begin
      sub_r <= sub_r + 11'h001;
    end
  end

  // a glitch shorter than one sample never changes the level
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ext_q1_r  <= 1'b0;
      ext_q2_r  <= 1'b0;
      ext_q3_r  <= 1'b0;
      ext_lvl_r <= 1'b0;
    end else begin
      ext_q1_r <= external_clock_pin;
      ext_q2_r <= ext_q1_r;
      ext_q3_r <= ext_q2_r;
      if (ext_q2_r == ext_q3_r) begin
        ext_lvl_r <= ext_q3_r;
      end
    end
  end

  assign ext_rise = (ext_q2_r == ext_q3_r) && ext_q3_r && !ext_lvl_r;
  assign ext_fall = (ext_q2_r == ext_q3_r) && !ext_q3_r && ext_lvl_r;

  always_comb begin
    case (clock_select_field)
      stm_pkg::CK_SYS4: clk_en = (pre_r & stm_pkg::DIV4_MASK) == stm_pkg::DIV4_MASK;
      stm_pkg::CK_SYS:  clk_en = 1'b1;
      stm_pkg::CK_H16:  clk_en = (pre_r & stm_pkg::DIV16_MASK) == stm_pkg::DIV16_MASK;
      stm_pkg::CK_H64:  clk_en = pre_r == stm_pkg::DIV64_MASK;
      stm_pkg::CK_SUB0: clk_en = sub_r == stm_pkg::SUB_LAST;
      stm_pkg::CK_SUB1: clk_en = sub_r == stm_pkg::SUB_LAST;
      stm_pkg::CK_EXTR: clk_en = ext_rise;
      stm_pkg::CK_EXTF: clk_en = ext_fall;
      default:          clk_en = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // counter and comparators
  // ----------------------------------------------------------------
  logic        tick;
  logic        on_rise;
  logic        is_pwm;
  logic [15:0] cnt_inc;
  logic        hit_a;
  logic        hit_p;
  logic        clr;
  logic [16:0] duty_lim;
  logic        pwm_act;

  assign is_pwm  = mode_select_field == stm_pkg::MODE_PWM;
  assign on_rise = on_off_bit && !on_d_r;
  assign tick    = on_off_bit && !pause_bit && clk_en;
  assign cnt_inc = cnt_r + stm_pkg::CNT_ONE;
  // a zero comparator a never matches, so with a as clear source the count wraps at ffff
  assign hit_a = (cnt_inc == cmpa_r) && (cmpa_r != stm_pkg::CNT_RESET);
  // p zero matches on wrap, i.e. overflow clear with 65536 period
  assign hit_p = (cnt_inc[15:8] == cmpp_r) && (cnt_inc[7:0] == stm_pkg::BYTE_ZERO);

  always_comb begin
    if (is_pwm) begin
      clr = duty_period_select ? hit_a : hit_p;
    end else begin
      clr = counter_clear_select ? hit_a : hit_p;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      on_d_r <= 1'b0;
    end else begin
      on_d_r <= on_off_bit;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= stm_pkg::CNT_RESET;
    end else if (on_rise) begin
      cnt_r <= stm_pkg::CNT_RESET;
    end else if (tick) begin
      cnt_r <= clr ? stm_pkg::CNT_RESET : cnt_inc;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      compare_a_flag <= 1'b0;
      compare_p_flag <= 1'b0;
    end else begin
      compare_a_flag <= tick && !on_rise && hit_a;
      compare_p_flag <= tick && !on_rise && hit_p &&
                        (is_pwm || !counter_clear_select);
    end
  end

  // ----------------------------------------------------------------
  // output pin
  // ----------------------------------------------------------------
  // duty bound; p zero stands for 65536 so the output stays active
  always_comb begin
    if (duty_period_select) begin
      duty_lim = (cmpp_r == stm_pkg::BYTE_ZERO) ? 17'h1_0000 : {1'b0, cmpp_r, 8'h00};
    end else begin
      duty_lim = {1'b0, cmpa_r};
    end
  end
  // duty at or above the period is simply never reached: full duty
  assign pwm_act = {1'b0, cnt_r} < duty_lim;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pin_r <= 1'b0;
    end else if (on_rise && mode_select_field != stm_pkg::MODE_TC) begin
      pin_r <= output_control_bit;
    end else if (mode_select_field == stm_pkg::MODE_CMP) begin
      if (tick && hit_a) begin
        case (pin_function_field)
          stm_pkg::PINF_01: pin_r <= 1'b0;
          stm_pkg::PINF_10: pin_r <= 1'b1;
          stm_pkg::PINF_11: pin_r <= !pin_r;
          default:          pin_r <= pin_r;
        endcase
      end
    end else if (is_pwm) begin
      case (pin_function_field)
        stm_pkg::PINF_00: pin_r <= !output_control_bit;
        stm_pkg::PINF_01: pin_r <= output_control_bit;
        stm_pkg::PINF_10: pin_r <= pwm_act ? output_control_bit : !output_control_bit;
        // single pulse: active from switch-on until the first a match
        stm_pkg::PINF_11: begin
          if (tick && hit_a) begin
            pin_r <= !output_control_bit;
          end
        end
        default: pin_r <= pin_r;
      endcase
    end
  end

  // timer/counter mode releases the pin and drives it low internally
  assign timer_output_pin_oe = mode_select_field != stm_pkg::MODE_TC;
  assign timer_output_pin    = timer_output_pin_oe && (pin_r ^ polarity_bit);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  chk_on_rise_clear: assert property (on_rise |=> cnt_r == stm_pkg::CNT_RESET)
    else $error("counter not cleared on switch-on");
  chk_off_holds: assert property (!on_off_bit && !on_rise |=> $stable(cnt_r))
    else $error("counter moved while off");
  chk_pause_holds: assert property (pause_bit && on_off_bit && !on_rise |=> $stable(cnt_r))
    else $error("counter moved while paused");
  chk_count_step: assert property (tick && !on_rise && !clr |=> cnt_r == $past(cnt_r) + 16'h0001)
    else $error("counter did not step by one");
  chk_match_clear: assert property (tick && !on_rise && clr |=> cnt_r == stm_pkg::CNT_RESET)
    else $error("counter not cleared on match");
  chk_p_flag_off: assert property (counter_clear_select && !is_pwm |=> !compare_p_flag)
    else $error("p flag raised with clear select a");
  chk_pin_init: assert property (on_rise && mode_select_field != stm_pkg::MODE_TC
                                 |=> pin_r == $past(output_control_bit))
    else $error("pin not set to initial level");
  chk_pin_toggle: assert property (mode_select_field == stm_pkg::MODE_CMP && !on_rise &&
                                   pin_function_field == stm_pkg::PINF_11 && tick && hit_a
                                   |=> pin_r != $past(pin_r))
    else $error("pin did not toggle on match");
  chk_pin_release: assert property (mode_select_field == stm_pkg::MODE_TC
                                    |-> !timer_output_pin_oe)
    else $error("pin driven in timer mode");
  chk_read_latency: assert property (reg_rd && reg_addr == stm_pkg::ADDR_CNT_LO
                                     |=> reg_rdata == $past(cnt_r[7:0]))
    else $error("counter low byte read wrong");
  // pin levels, clear sources, unused control bits, sub divider range, a flag; a released pin must also read low
  chk_tc_pin_low: assert property (mode_select_field == stm_pkg::MODE_TC |-> !timer_output_pin)
    else $error("pin not low in timer mode");
  chk_ctrl0_zero: assert property ((ctrl0_r & ~stm_pkg::CTRL0_RD_MASK) == stm_pkg::BYTE_ZERO)
    else $error("unused control bits set");
  chk_sub_range: assert property (sub_r <= stm_pkg::SUB_LAST)
    else $error("sub clock divider out of range");
  chk_p_clear: assert property (tick && !on_rise && hit_p && !is_pwm && !counter_clear_select
                                |=> cnt_r == stm_pkg::CNT_RESET)
    else $error("counter not cleared on p match");
  chk_a_zero_flag: assert property (cmpa_r == stm_pkg::CNT_RESET |=> !compare_a_flag)
    else $error("a flag raised with zero compare a");
  chk_pwm_active: assert property (is_pwm && pin_function_field == stm_pkg::PINF_01
                                   |=> pin_r == $past(output_control_bit))
    else $error("pwm forced active level wrong");
  chk_pwm_idle: assert property (is_pwm && pin_function_field == stm_pkg::PINF_00 && !on_rise
                                 |=> pin_r == !$past(output_control_bit))
    else $error("pwm forced inactive level wrong");
  chk_dpx_clear: assert property (tick && !on_rise && hit_a && is_pwm && duty_period_select
                                  |=> cnt_r == stm_pkg::CNT_RESET)
    else $error("pwm period not set by compare a");

  // covers mark the main scenarios only, they check nothing
  cov_p_wrap: cover property (tick && hit_p && cmpp_r == stm_pkg::BYTE_ZERO);
  cov_single_pulse: cover property (is_pwm && pin_function_field == stm_pkg::PINF_11 &&
                                    tick && hit_a);
  cov_a_match: cover property (compare_a_flag ##1 compare_a_flag [*1] or compare_a_flag);
  cov_pwm_run: cover property (is_pwm && pin_function_field == stm_pkg::PINF_10 && tick);
  cov_ext_edge: cover property (ext_rise ##[1:20] ext_fall);
endmodule : standard_timer_module
`default_nettype wire

/* File: tb/ext_pin_model.sv */
// partner model: source of the external count clock
`default_nettype none
module ext_pin_model (
  input  wire logic        run,
  input  wire logic [15:0] half_ns,
  output logic             external_clock_pin,
  output logic      [15:0] rise_cnt,
  output logic      [15:0] fall_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // edge source
  // ------------------------------------------------------------
  // phase is free of the system clock; the line holds its level while stopped
  initial begin
    external_clock_pin = 1'b0;
    rise_cnt = 16'h0000;
    fall_cnt = 16'h0000;
    forever begin
      wait (run === 1'b1);
      #(half_ns);
      if (run === 1'b1) begin
        external_clock_pin = ~external_clock_pin;
        if (external_clock_pin) begin
          rise_cnt = rise_cnt + 16'h0001;
        end else begin
          fall_cnt = fall_cnt + 16'h0001;
        end
      end
    end
  end
endmodule : ext_pin_model
`default_nettype wire

/* File: tb/standard_timer_module_tb_top.sv */
// self-checking testbench for the standard timer module
`default_nettype none
module standard_timer_module_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // signals and instances
  // ------------------------------------------------------------
  typedef struct packed {
    logic [1:0] pinf;
    logic       oc;
    logic       pol;
    logic       exp_init;
    logic       exp_after;
  } pin_row_t;
  // index map: 0 ctrl0, 1 ctrl1, 2/3 counter, 4/5 compare a, 6 compare p
  pin_row_t    pin_rows [8] = '{'{2'h0, 1'b0, 1'b0, 1'b0, 1'b0}, '{2'h0, 1'b1, 1'b1, 1'b0, 1'b0},
                                '{2'h1, 1'b0, 1'b0, 1'b0, 1'b0}, '{2'h1, 1'b1, 1'b0, 1'b1, 1'b0},
                                '{2'h2, 1'b0, 1'b1, 1'b1, 1'b0}, '{2'h2, 1'b1, 1'b0, 1'b1, 1'b1},
                                '{2'h3, 1'b0, 1'b0, 1'b0, 1'b1}, '{2'h3, 1'b1, 1'b1, 1'b0, 1'b1}};
  logic        ref_clk;
  logic        nrst;
  logic [2:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  logic        external_clock_pin;
  logic        timer_output_pin;
  logic        timer_output_pin_oe;
  logic        compare_a_flag;
  logic        compare_p_flag;
  logic        ext_run;
  logic [15:0] ext_half;
  logic [15:0] rise_cnt;
  logic [15:0] fall_cnt;
  logic [15:0] base;
  logic [7:0]  rd;
  logic [7:0]  rd2;
  int          bad_count;
  int          cmp_count;
  int          n;

  standard_timer_module standard_timer_module_i (
    .ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .external_clock_pin(external_clock_pin), .timer_output_pin(timer_output_pin),
    .timer_output_pin_oe(timer_output_pin_oe), .compare_a_flag(compare_a_flag),
    .compare_p_flag(compare_p_flag));
  ext_pin_model ext_pin_model_i (
    .run(ext_run), .half_ns(ext_half), .external_clock_pin(external_clock_pin),
    .rise_cnt(rise_cnt), .fall_cnt(fall_cnt));

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] expd);
    cmp_count++;
    if (seen !== expd) begin
      bad_count++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, expd);
    end
  endtask : check

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop

  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr_reg

  // read data stand from the cycle after the read edge until the next read
  task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    d = reg_rdata;
  endtask : rd_reg

  // switch off first so pin function and mode never change while running
  task automatic restart(input logic [7:0] c1, input logic [15:0] ca, input logic [7:0] c0);
    wr_reg(3'h0, 8'h00);
    wr_reg(3'h1, c1);
    wr_reg(3'h4, ca[7:0]);
    wr_reg(3'h5, ca[15:8]);
    wr_reg(3'h0, c0);
  endtask : restart

  // cycles up to the next flag; a lost flag ends the run
  task automatic wait_flag(input logic use_a, output int cyc);
    cyc = 0;
    do begin
      @(negedge ref_clk);
      cyc++;
    end while ((use_a ? compare_a_flag : compare_p_flag) !== 1'b1 && cyc < 70000);
    if (cyc >= 70000) begin
      bad_count++;
      report_and_stop();
    end
  endtask : wait_flag

  task automatic pwm_case(input logic [7:0] c1, input logic [15:0] ca, input int per,
                          input int exp_high);
    int hi;
    restart(c1, ca, 8'h18);
    wait_flag(c1[1], hi);
    hi = 0;
    repeat (per) begin
      @(negedge ref_clk);
      if (timer_output_pin === 1'b1) hi++;
    end
    check(16'(hi), 16'(exp_high));
  endtask : pwm_case
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    ext_run = 1'b0;
    ext_half = 16'h0083;
    bad_count = 0;
    cmp_count = 0;
    repeat (5) @(posedge ref_clk);
    nrst <= 1'b1;
    for (int a = 0; a < 8; a++) begin
      rd_reg(3'(a), rd);
      check(16'(rd), 16'h0000);
    end
    for (int a = 1; a < 8; a++) begin
      wr_reg(3'(a), 8'ha5);
      rd_reg(3'(a), rd);
      check(16'(rd), (a inside {1, 4, 5, 6}) ? 16'h00a5 : 16'h0000);
    end
    wr_reg(3'h0, 8'hf7);
    rd_reg(3'h0, rd);
    check(16'(rd), 16'h00f0);
    // compare mode pin actions, one row each
    foreach (pin_rows[i]) begin
      restart({2'b00, pin_rows[i].pinf, pin_rows[i].oc, pin_rows[i].pol, 2'b01}, 16'h0004,
              8'h18);
      repeat (2) @(negedge ref_clk);
      check(16'(timer_output_pin), 16'(pin_rows[i].exp_init));
      check(16'(timer_output_pin_oe), 16'h0001);
      wait_flag(1'b1, n);
      @(negedge ref_clk);
      check(16'(timer_output_pin), 16'(pin_rows[i].exp_after));
    end
    // every internal clock select, a flag every 2 ticks
    for (int k = 0; k < 6; k++) begin
      restart(8'hc1, 16'h0002, {1'b0, 3'(k), 4'h8});
      wait_flag(1'b1, n);
      wait_flag(1'b1, n);
      check(16'(n), 16'(2 * ((k == 0) ? 4 : (k == 1) ? 1 : (k == 2) ? 16 :
                            (k == 3) ? 64 : stm_pkg::SUB_DIV)));
    end
    check(16'(timer_output_pin_oe), 16'h0000);
    wr_reg(3'h6, 8'h01);
    restart(8'hc0, 16'h0003, 8'h18);
    wait_flag(1'b0, n);
    wait_flag(1'b0, n);
    check(16'(n), 16'h0100);
    wait_flag(1'b1, n);
    wait_flag(1'b1, n);
    check(16'(n), 16'h0100);
    restart(8'hc1, 16'h0000, 8'h18);
    n = 0;
    repeat (300) begin
      @(negedge ref_clk);
      if (compare_a_flag !== 1'b0 || compare_p_flag !== 1'b0) n++;
    end
    check(16'(n), 16'h0000);
    wr_reg(3'h0, 8'h98);
    rd_reg(3'h2, rd);
    repeat (10) @(posedge ref_clk);
    rd_reg(3'h2, rd2);
    check(16'(rd2), 16'(rd));
    wr_reg(3'h0, 8'h18);
    rd_reg(3'h2, rd2);
    check(16'(rd2 > rd), 16'h0001);
    wr_reg(3'h0, 8'h10);
    rd_reg(3'h2, rd);
    repeat (10) @(posedge ref_clk);
    rd_reg(3'h2, rd2);
    check(16'(rd2), 16'(rd));
    wr_reg(3'h0, 8'h98);
    rd_reg(3'h2, rd);
    rd_reg(3'h3, rd2);
    check({rd2, rd}, 16'h0000);
    // external pin, rising then falling edges, fast then slow source
    for (int k = 0; k < 2; k++) begin
      restart(8'hc1, 16'h0000, k ? 8'h78 : 8'h68);
      base = k ? fall_cnt : rise_cnt;
      ext_half <= k ? 16'h00d5 : 16'h0083;
      ext_run <= 1'b1;
      repeat (200) @(posedge ref_clk);
      ext_run <= 1'b0;
      repeat (20) @(posedge ref_clk);
      rd_reg(3'h2, rd);
      check(16'(rd), (k ? fall_cnt : rise_cnt) - base);
    end
    // pwm: period/duty roles, polarity, full duty, forced levels, single pulse
    wr_reg(3'h6, 8'h01);
    pwm_case(8'ha8, 16'h0040, 256, 64);
    pwm_case(8'hac, 16'h0040, 256, 192);
    pwm_case(8'haa, 16'h0200, 512, 256);
    pwm_case(8'ha8, 16'h0100, 256, 256);
    pwm_case(8'h98, 16'h0040, 256, 256);
    pwm_case(8'h88, 16'h0040, 256, 0);
    pwm_case(8'hb8, 16'h0040, 256, 0);
    // reset in mid-run
    @(posedge ref_clk);
    nrst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    rd_reg(3'h1, rd);
    rd_reg(3'h2, rd2);
    check({rd, rd2}, 16'h0000);
    report_and_stop();
  end
endmodule : standard_timer_module_tb_top
`default_nettype wire
